// *** logic/gse_defs.vh ***
// Register offsets, field positions and reset values for the status/event bank
`ifndef GSE_DEFS_VH
`define GSE_DEFS_VH

`define GSE_ADDR_W 8
`define GSE_OFF_STATUS 8'h85
`define GSE_OFF_CONTROL 8'h86
`define GSE_OFF_EVT_STS 8'h88
`define GSE_OFF_EVT_EN 8'h89
`define GSE_OFF_INPUTS 8'h8A

`define GSE_RST_BYTE 8'h00
`define GSE_ZERO_BYTE 8'h00

// Status register fields
`define GSE_ST_SEL_DET 7
`define GSE_ST_PRESENT 2
`define GSE_ST_DATA_ERR 1
`define GSE_ST_LOADING 0

// Control register fields
`define GSE_CT_OHCI_DIS 3
`define GSE_CT_GPO_I2C 2
`define GSE_CT_ARB_HI 1
`define GSE_CT_ARB_LO 0
`define GSE_CTRL_MASK 8'h0F

// Event fields
`define GSE_EV_POWER 7
`define GSE_EV_VPP 6
`define GSE_EV_MASK 8'hCF
`define GSE_IN_MASK 8'h0F

// Arbitration encodings
`define GSE_ARB_OHCI 2'h0
`define GSE_ARB_CARDBUS 2'h1

`endif

// *** logic/gse_edge_sync.v ***
// Two-stage synchroniser with level-change detection for the input pins
`default_nettype none

module gse_edge_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Asynchronous pins
  input wire [WIDTH-1:0] pin_async,
  // Synchronised level and change pulse
  output reg [WIDTH-1:0] level_r,
  output wire [WIDTH-1:0] change
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  reg primed_r;

  // The first stage feeds no logic; the second and third stages do
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
      level_r <= {WIDTH{1'b0}};
      primed_r <= 1'b0;
    end else begin
      meta_r <= pin_async;
      sync_r <= meta_r;
      level_r <= sync_r;
      primed_r <= 1'b1;
    end
  end

  // Change masked only in the first cycle after reset, not for the whole pipeline fill
  assign change = primed_r ? (sync_r ^ level_r) : {WIDTH{1'b0}};

endmodule // gse_edge_sync

`default_nettype wire

// *** logic/gse_regs.v ***
// General status, control and event register bank
// Functional notes
// - Status bit 7 reports select pin working as configuration select input.
// - Status bits 6-3 and control bits 7-4 read zero.
// - eeprom_present set if serial clock sampled high at secondary reset.
// - eeprom_data_error set on EEPROM error; software writes one to clear.
// - eeprom_loading high while EEPROM engine loads subsystem identifier.
// - Only global reset returns marked bits to defaults.
// - ohci_disable makes the 1394 controller inaccessible and idle.
// - gpo_to_i2c routes output 0 to SDA and output 1 to SCL.
// - arb_priority: 00 1394, 01 CardBus, 10/11 fair round robin.
// - power_change_flag set on any socket VCC or VPP power change.
// - vpp_high_flag set when VPP request changes to or from 12 V.
// - Event bit n set on input n change while configured as input.
// - General event output when any enabled status bit is set.
// - Event status/enable bits 5-4 read zero, writes ignored.
// - Input register bits 3-0 follow general-purpose input levels.
// - Input register bits 7-4 read zero, writes ignored.
`default_nettype none
`include "gse_defs.vh"

module gse_regs #(
  parameter NUM_GPI = 4
) (
  // Clock and global reset
  input wire clk,
  input wire rst_n,
  // Secondary reset, active low, from the device's reset logic
  input wire secondary_reset_n,
  // Configuration register access
  input wire cfg_func0,
  input wire [`GSE_ADDR_W-1:0] cfg_addr,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_wdata,
  output reg [7:0] cfg_rdata_r,
  // EEPROM engine status
  input wire eeprom_scl_in,
  input wire eeprom_busy,
  input wire eeprom_err_pulse,
  // Pin configuration
  input wire select_pin_is_idsel,
  input wire [NUM_GPI-1:0] pin_is_gpi,
  input wire [NUM_GPI-1:0] gpi_pins,
  // Socket power change events
  input wire power_change_pulse,
  input wire vpp12_change_pulse,
  // General-purpose outputs from the output register
  input wire [1:0] gpo_low,
  // Steering outputs
  output reg ohci_disable_r,
  output reg [1:0] arb_priority_r,
  output reg gpo_to_i2c_r,
  output reg sda_out_r,
  output reg sda_oe_r,
  output reg scl_out_r,
  output reg scl_oe_r,
  output reg general_event_output_r
);

  // =========================================
  // Pin synchronisation
  // =========================================
  reg [2:0] pin_meta_r;
  reg [2:0] pin_sync_r;
  wire [NUM_GPI-1:0] gpi_level;
  wire [NUM_GPI-1:0] gpi_change;

  gse_edge_sync #(
    .WIDTH(NUM_GPI)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_async(gpi_pins),
    .level_r(gpi_level),
    .change(gpi_change)
  );

  // SCL, secondary reset and select straps pass two stages
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {select_pin_is_idsel, secondary_reset_n, eeprom_scl_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire scl_sync = pin_sync_r[0];
  wire sec_rst_active = ~pin_sync_r[1];
  wire sel_sync = pin_sync_r[2];

  // =========================================
  // Register state
  // =========================================
  reg sel_det_r;
  reg present_r;
  reg data_err_r;
  reg loading_r;
  reg [7:0] evt_sts_r;
  reg [7:0] evt_en_r;
  reg [7:0] evt_sts_nxt;
  reg [7:0] evt_set;

  function automatic hit;
    input [`GSE_ADDR_W-1:0] a;
    input [`GSE_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire wr_status = cfg_wr && cfg_func0 && hit(cfg_addr, `GSE_OFF_STATUS);
  wire wr_ctrl = cfg_wr && hit(cfg_addr, `GSE_OFF_CONTROL);
  wire wr_evt_sts = cfg_wr && hit(cfg_addr, `GSE_OFF_EVT_STS);
  wire wr_evt_en = cfg_wr && hit(cfg_addr, `GSE_OFF_EVT_EN);

  // =========================================
  // Event status next value
  // =========================================
  always @* begin
    evt_set = `GSE_ZERO_BYTE;
    evt_set[`GSE_EV_POWER] = power_change_pulse;
    evt_set[`GSE_EV_VPP] = vpp12_change_pulse;
    evt_set[NUM_GPI-1:0] = gpi_change & pin_is_gpi;
    evt_sts_nxt = evt_sts_r;
    if (wr_evt_sts) begin
      evt_sts_nxt = evt_sts_r & ~cfg_wdata;
    end
    evt_sts_nxt = (evt_sts_nxt | evt_set) & `GSE_EV_MASK;
  end

  // =========================================
  // Registers, cleared only by global reset
  // =========================================
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_det_r <= 1'b0;
      present_r <= 1'b0;
      data_err_r <= 1'b0;
      loading_r <= 1'b0;
      ohci_disable_r <= 1'b0;
      gpo_to_i2c_r <= 1'b0;
      arb_priority_r <= `GSE_ARB_OHCI;
      evt_sts_r <= `GSE_RST_BYTE;
      evt_en_r <= `GSE_RST_BYTE;
    end else begin
      sel_det_r <= sel_sync;
      loading_r <= eeprom_busy;
      // Detect latched while secondary reset is held
      if (sec_rst_active) begin
        present_r <= scl_sync;
      end
      if (eeprom_err_pulse) begin
        data_err_r <= 1'b1;
      end else if (wr_status && cfg_wdata[`GSE_ST_DATA_ERR]) begin
        data_err_r <= 1'b0;
      end
      if (wr_ctrl) begin
        ohci_disable_r <= cfg_wdata[`GSE_CT_OHCI_DIS];
        gpo_to_i2c_r <= cfg_wdata[`GSE_CT_GPO_I2C];
        arb_priority_r <= cfg_wdata[`GSE_CT_ARB_HI:`GSE_CT_ARB_LO];
      end
      evt_sts_r <= evt_sts_nxt;
      if (wr_evt_en) begin
        evt_en_r <= cfg_wdata & `GSE_EV_MASK;
      end
    end
  end

  // =========================================
  // Outputs
  // =========================================
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      general_event_output_r <= 1'b0;
      sda_out_r <= 1'b0;
      sda_oe_r <= 1'b0;
      scl_out_r <= 1'b0;
      scl_oe_r <= 1'b0;
    end else begin
      general_event_output_r <= |(evt_sts_nxt & evt_en_r);
      sda_out_r <= gpo_low[0];
      scl_out_r <= gpo_low[1];
      sda_oe_r <= gpo_to_i2c_r;
      scl_oe_r <= gpo_to_i2c_r;
    end
  end

  // =========================================
  // Read data
  // =========================================
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = `GSE_ZERO_BYTE;
    if (hit(cfg_addr, `GSE_OFF_STATUS)) begin
      rd_mux[`GSE_ST_SEL_DET] = sel_det_r;
      rd_mux[`GSE_ST_PRESENT] = present_r;
      rd_mux[`GSE_ST_DATA_ERR] = data_err_r;
      rd_mux[`GSE_ST_LOADING] = loading_r;
    end else if (hit(cfg_addr, `GSE_OFF_CONTROL)) begin
      rd_mux[`GSE_CT_OHCI_DIS] = ohci_disable_r;
      rd_mux[`GSE_CT_GPO_I2C] = gpo_to_i2c_r;
      rd_mux[`GSE_CT_ARB_HI:`GSE_CT_ARB_LO] = arb_priority_r;
    end else if (hit(cfg_addr, `GSE_OFF_EVT_STS)) begin
      rd_mux = evt_sts_r;
    end else if (hit(cfg_addr, `GSE_OFF_EVT_EN)) begin
      rd_mux = evt_en_r;
    end else if (hit(cfg_addr, `GSE_OFF_INPUTS)) begin
      rd_mux[NUM_GPI-1:0] = gpi_level;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_r <= `GSE_ZERO_BYTE;
    end else if (cfg_rd) begin
      cfg_rdata_r <= rd_mux;
    end
  end

endmodule // gse_regs

`default_nettype wire

// *** tb/gse_regs_chk.sv ***
// Port-level checker for the status/event register bank
`default_nettype none
module gse_regs_chk #(
  parameter NUM_GPI = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Config access
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata_r,
  // Pins
  input wire logic [NUM_GPI-1:0] gpi_pins,
  input wire logic [1:0] gpo_low,
  // Outputs
  input wire logic ohci_disable_r,
  input wire logic [1:0] arb_priority_r,
  input wire logic gpo_to_i2c_r,
  input wire logic sda_out_r,
  input wire logic sda_oe_r,
  input wire logic scl_out_r,
  input wire logic scl_oe_r,
  input wire logic general_event_output_r
);
  logic [2:0] calm_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles the input pins have held still
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) calm_r <= 3'h0;
    else if (gpi_pins != $past(gpi_pins)) calm_r <= 3'h0;
    else if (calm_r != 3'h7) calm_r <= calm_r + 3'h1;
  end
  ctrl_write_a: assert property (cfg_wr && cfg_addr == 8'h86 |=>
    {ohci_disable_r, gpo_to_i2c_r, arb_priority_r} == $past(cfg_wdata[3:0])) else $error("ctrl");
  pin_steer_a: assert property ($past(rst_n) |-> {sda_oe_r, scl_oe_r} ==
    {2{$past(gpo_to_i2c_r)}} && {scl_out_r, sda_out_r} == $past(gpo_low)) else $error("steer");
  unmapped_zero_a: assert property (cfg_rd && !(cfg_addr inside {8'h85, 8'h86, 8'h88,
    8'h89, 8'h8A}) |=> cfg_rdata_r == 8'h00) else $error("unmapped");
  status_resv_a: assert property (cfg_rd && cfg_addr == 8'h85 |=>
    cfg_rdata_r[6:3] == 4'h0) else $error("status");
  ctrl_resv_a: assert property (cfg_rd && cfg_addr == 8'h86 |=>
    cfg_rdata_r[7:4] == 4'h0) else $error("ctrl resv");
  event_resv_a: assert property (cfg_rd && cfg_addr inside {8'h88, 8'h89} |=>
    cfg_rdata_r[5:4] == 2'h0) else $error("event resv");
  rdata_hold_a: assert property (!cfg_rd |=> $stable(cfg_rdata_r)) else $error("rdata");
  event_clear_a: assert property ($fell(general_event_output_r) |->
    $past(cfg_wr) || $past(cfg_wr, 2)) else $error("event fall");
  input_level_a: assert property (cfg_rd && cfg_addr == 8'h8A && calm_r == 3'h7 |=>
    cfg_rdata_r == {4'h0, $past(gpi_pins)}) else $error("inputs");
endmodule // gse_regs_chk
bind gse_regs gse_regs_chk #(.NUM_GPI(NUM_GPI)) chk_i (.clk, .rst_n, .cfg_addr, .cfg_wr,
  .cfg_rd, .cfg_wdata, .cfg_rdata_r, .gpi_pins, .gpo_low, .ohci_disable_r, .arb_priority_r,
  .gpo_to_i2c_r, .sda_out_r, .sda_oe_r, .scl_out_r, .scl_oe_r, .general_event_output_r);
`default_nettype wire

// *** tb/gse_regs_tb.sv ***
// Self-checking bench for the status/event register bank
`default_nettype none
module gse_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, secondary_reset_n, cfg_func0, cfg_wr, cfg_rd, eeprom_scl_in;
  logic eeprom_busy, eeprom_err_pulse, select_pin_is_idsel, power_change_pulse;
  logic vpp12_change_pulse, ohci_disable_r, gpo_to_i2c_r, sda_out_r, sda_oe_r;
  logic scl_out_r, scl_oe_r, general_event_output_r;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata_r, d;
  logic [3:0] pin_is_gpi, gpi_pins;
  logic [1:0] gpo_low, arb_priority_r;
  logic [7:0] tbl [5] = '{8'h86, 8'h89, 8'h8A, 8'h87, 8'h8B};
  int error_cnt = 0, checks_done = 0, j;
  gse_regs #(.NUM_GPI(4)) dut (.clk, .rst_n, .secondary_reset_n, .cfg_func0, .cfg_addr,
    .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata_r, .eeprom_scl_in, .eeprom_busy,
    .eeprom_err_pulse, .select_pin_is_idsel, .pin_is_gpi, .gpi_pins, .power_change_pulse,
    .vpp12_change_pulse, .gpo_low, .ohci_disable_r, .arb_priority_r, .gpo_to_i2c_r,
    .sda_out_r, .sda_oe_r, .scl_out_r, .scl_oe_r, .general_event_output_r);
  // ==========
  // Tasks
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    cfg_addr = a;
    cfg_wdata = v;
    cfg_wr = 1'h1;
    tick();
    cfg_wr = 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, e);
    cfg_addr = a;
    cfg_rd = 1'h1;
    tick();
    cfg_rd = 1'h0;
    chk(cfg_rdata_r, e);
  endtask
  task automatic pulse(input logic [1:0] p);
    {power_change_pulse, vpp12_change_pulse} = p;
    tick();
    {power_change_pulse, vpp12_change_pulse} = 2'h0;
    tick(2);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a, v);
    if (a == 8'h86) return v & 8'h0F;
    if (a == 8'h89) return v & 8'hCF;
    return 8'h00;
  endfunction
  // ==========
  // Stimulus
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #50us;
    error_cnt++;
    end_sim();
  end
  initial begin
    {rst_n, secondary_reset_n, cfg_func0, cfg_wr, cfg_rd, eeprom_scl_in} = 6'h00;
    {eeprom_busy, eeprom_err_pulse, select_pin_is_idsel, power_change_pulse} = 4'h0;
    {vpp12_change_pulse, gpo_low, cfg_addr, cfg_wdata, pin_is_gpi, gpi_pins} = 27'h0;
    void'($urandom(17552));
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'h1;
    cfg_func0 = 1'h1;
    tick(3);
    secondary_reset_n = 1'h1;
    tick(4);
    for (int a = 8'h85; a < 8'h8C; a++) rc(8'(a), 8'h00);
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom);
      d[1:0] = 2'(i);
      wr(tbl[i % 5], d);
      rc(tbl[i % 5], exp_rd(tbl[i % 5], d));
      chk({4'h0, ohci_disable_r, gpo_to_i2c_r, arb_priority_r},
        (tbl[i % 5] == 8'h86) ? exp_rd(8'h86, d) : 8'h00);
      wr(8'h86, 8'h00);
    end
    wr(8'h89, 8'hFF);
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'h40 : 8'h80;
      pulse(k ? 2'h1 : 2'h2);
      chk({7'h0, general_event_output_r}, 8'h01);
      wr(8'h88, 8'h00);
      rc(8'h88, d);
      {power_change_pulse, vpp12_change_pulse} = k ? 2'h1 : 2'h2;
      wr(8'h88, d);
      {power_change_pulse, vpp12_change_pulse} = 2'h0;
      rc(8'h88, d);
      wr(8'h88, d);
      tick(2);
      chk({7'h0, general_event_output_r}, 8'h00);
      rc(8'h88, 8'h00);
    end
    wr(8'h89, 8'h0F);
    pulse(2'h2);
    chk({7'h0, general_event_output_r}, 8'h00);
    pin_is_gpi = 4'hF;
    for (int i = 0; i < 6; i++) begin
      j = $urandom % 4;
      gpi_pins[j] = ~gpi_pins[j];
      tick(8);
      rc(8'h88, 8'h80 | (8'h01 << j));
      rc(8'h8A, {4'h0, gpi_pins});
      wr(8'h88, 8'h01 << j);
    end
    pin_is_gpi = 4'h0;
    gpi_pins = ~gpi_pins;
    tick(8);
    rc(8'h88, 8'h80);
    eeprom_err_pulse = 1'h1;
    tick();
    eeprom_err_pulse = 1'h0;
    rc(8'h85, 8'h02);
    cfg_func0 = 1'h0;
    wr(8'h85, 8'h02);
    rc(8'h85, 8'h02);
    cfg_func0 = 1'h1;
    wr(8'h85, 8'h02);
    rc(8'h85, 8'h00);
    {eeprom_scl_in, secondary_reset_n} = 2'h2;
    tick(4);
    secondary_reset_n = 1'h1;
    tick(4);
    {eeprom_scl_in, eeprom_busy, select_pin_is_idsel} = 3'h3;
    tick(5);
    rc(8'h85, 8'h85);
    rc(8'h88, 8'h80);
    wr(8'h86, 8'h04);
    gpo_low = 2'($urandom);
    tick(3);
    chk({4'h0, sda_oe_r, scl_oe_r, scl_out_r, sda_out_r}, {6'h03, gpo_low});
    end_sim();
  end
endmodule // gse_regs_tb
`default_nettype wire
